// ### rtl/ssp_regs_pkg.sv
`default_nettype none
package ssp_regs_pkg;
    // Register byte addresses on the word bus
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_DATA = 4'h8;
    localparam logic [3:0] ADDR_BAUD = 4'hC;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    // Status field positions
    localparam int SAMPLE_SEL_BIT = 7;
    localparam int CKE_BIT = 6;
    localparam int DA_BIT = 5;
    localparam int STOP_BIT = 4;
    localparam int START_BIT = 3;
    localparam int DIR_BIT = 2;
    localparam int UPDATE_ADDR_BIT = 1;
    localparam int FULL_BIT = 0;
    // Control field positions
    localparam int COLLISION_BIT = 7;
    localparam int OV_BIT = 6;
    localparam int EN_BIT = 5;
    localparam int POLARITY_BIT = 4;
    // Mode select codes
    localparam logic [3:0] MODE_SPI_M4 = 4'h0;
    localparam logic [3:0] MODE_SPI_M16 = 4'h1;
    localparam logic [3:0] MODE_SPI_M64 = 4'h2;
    localparam logic [3:0] MODE_SPI_MT2 = 4'h3;
    localparam logic [3:0] MODE_SPI_S_SS = 4'h4;
    localparam logic [3:0] MODE_SPI_S = 4'h5;
    localparam logic [3:0] MODE_I2C_S7 = 4'h6;
    localparam logic [3:0] MODE_I2C_S10 = 4'h7;
    localparam logic [3:0] MODE_I2C_M = 4'h8;
    localparam logic [3:0] MODE_SPI_MBRG = 4'hA;
    localparam logic [3:0] MODE_I2C_FW = 4'hB;
    localparam logic [3:0] MODE_I2C_S7I = 4'hE;
    localparam logic [3:0] MODE_I2C_S10I = 4'hF;
    // Events reported by the serial engine
    typedef struct packed {
        logic byte_done;
        logic byte_is_data;
        logic start_seen;
        logic stop_seen;
        logic nack_seen;
        logic addr_match;
        logic addr_rw;
        logic need_addr;
        logic tx_busy;
        logic tx_done;
        logic [7:0] rx_byte;
    } ssp_event_t;
    // Decoded mode
    typedef struct packed {
        logic spi_master;
        logic spi_slave;
        logic ss_used;
        logic i2c_master;
        logic i2c_slave;
        logic ten_bit;
        logic cond_irq;
        logic reserved;
    } ssp_mode_t;
endpackage
`default_nettype wire

// ### rtl/ssp_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Turns the four-bit mode code into role flags
module ssp_mode_decode
(
    input wire logic [3:0] mode_in,
    output var ssp_regs_pkg::ssp_mode_t mode_out
);
    import ssp_regs_pkg::*;
    // Pure decode of the mode table
    always_comb
    begin
        mode_out = '0;
        case (mode_in)
            MODE_SPI_M4, MODE_SPI_M16, MODE_SPI_M64, MODE_SPI_MT2,
            MODE_SPI_MBRG:
                mode_out.spi_master = 1'b1;
            MODE_SPI_S_SS:
            begin
                mode_out.spi_slave = 1'b1;
                mode_out.ss_used = 1'b1;
            end
            MODE_SPI_S:
                mode_out.spi_slave = 1'b1;
            MODE_I2C_S7:
                mode_out.i2c_slave = 1'b1;
            MODE_I2C_S10:
            begin
                mode_out.i2c_slave = 1'b1;
                mode_out.ten_bit = 1'b1;
            end
            MODE_I2C_S7I:
            begin
                mode_out.i2c_slave = 1'b1;
                mode_out.cond_irq = 1'b1;
            end
            MODE_I2C_S10I:
            begin
                mode_out.i2c_slave = 1'b1;
                mode_out.ten_bit = 1'b1;
                mode_out.cond_irq = 1'b1;
            end
            MODE_I2C_M, MODE_I2C_FW:
                mode_out.i2c_master = 1'b1;
            default:
                mode_out.reserved = 1'b1;
        endcase
    end
endmodule // ssp_mode_decode
`default_nettype wire

// ### rtl/ssp_status_control.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Sample select picks end or middle sampling in SPI master; zero in slave.
// - Clock edge select: 1 shifts on active-to-idle, 0 on idle-to-active.
// - Data/address flag shows whether the last I2C byte was data.
// - Stop flag set on last Stop; zero at reset and when disabled.
// - Start flag set on last Start; zero at reset and when disabled.
// - Slave direction flag holds last matched R/W until Start, Stop, NACK.
// - Master direction flag shows transmit; OR with requests shows idle.
// - Update-address flag asks software to reload the address register.
// - Buffer-full set when a received byte lands in the data buffer.
// - In I2C transmit buffer-full stays high while data bits shift.
// - Write collision set by hardware on bad buffer writes; software clears.
// - SPI slave overflow: byte arrives while buffer full; new byte lost.
// - SPI slave software reads the buffer after every transfer.
// - I2C overflow set when a byte arrives while the buffer is full.
// - Port enable hands pins to the serial port, else general I/O; reserved mode codes keep general I/O.
// - Clock polarity sets SPI clock idle level.
// - I2C slave clock release: 0 stretches the clock, 1 releases it.
// - Codes 0000-0010 select SPI master at osc/4, /16, /64.
// - Code 0011 uses timer two half rate; 1010 uses baud divider.
// - Codes 0100 and 0101 select SPI slave with or without select pin.
// - Codes 0110, 0111, 1110, 1111 select I2C slave variants.
// - 1000 I2C master, 1011 firmware master; 1001, 1100, 1101 reserved.
module ssp_status_control
(
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [3:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire ssp_regs_pkg::ssp_event_t EVENT_IN,
    input wire logic BUS_CAN_START_IN,
    input wire logic [4:0] MASTER_REQ_IN,
    output logic PORT_ENABLE_OUT,
    output logic [3:0] MODE_SELECT_OUT,
    output logic SAMPLE_AT_END_OUT,
    output logic SHIFT_ON_IDLE_EDGE_OUT,
    output logic CLOCK_IDLE_HIGH_OUT,
    output logic SCL_HOLD_LOW_OUT,
    output logic [7:0] TX_BYTE_OUT,
    output logic TX_LOAD_OUT,
    output logic [7:0] BAUD_OUT,
    output logic PORT_IDLE_OUT
);
    import ssp_regs_pkg::*;

    logic [7:0] status;
    logic [1:0] spi_options;
    logic data_flag;
    logic stop_flag;
    logic start_flag;
    logic direction_flag;
    logic update_address_flag;
    logic buffer_full_flag;
    logic [7:0] control;
    logic [7:0] data_buffer;
    logic [7:0] address_baud_register;
    ssp_mode_t mode;
    logic wr;
    logic rd;
    logic lane0;
    logic [7:0] wbyte;
    logic data_write;
    logic data_read;
    logic i2c;
    logic rx_take;
    logic overflow_event;
    logic collision_event;
    logic [7:0] next_read;

    ssp_mode_decode u_decode
    (
        .mode_in(control[3:0]),
        .mode_out(mode)
    );

    // Bus decode: one access per request, acked after one wait
    assign wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT;
    assign rd = WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !WB_ACK_OUT;
    assign lane0 = WB_SEL_IN[0];
    assign wbyte = WB_DAT_IN[7:0];
    assign data_write = wr && lane0 && (WB_ADR_IN == ADDR_DATA);
    assign data_read = rd && (WB_ADR_IN == ADDR_DATA);
    assign i2c = mode.i2c_master || mode.i2c_slave;

    // Overflow and collision detection
    assign rx_take = EVENT_IN.byte_done && !EVENT_IN.tx_busy;
    assign overflow_event = rx_take && buffer_full_flag &&
        (mode.spi_slave || i2c);
    assign collision_event = data_write &&
        ((mode.i2c_master && !BUS_CAN_START_IN) ||
         (!mode.spi_master && !mode.i2c_master && EVENT_IN.tx_busy));

    // Acknowledge: single wait state, dropped the cycle after
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            WB_ACK_OUT <= 1'b0;
        else
            WB_ACK_OUT <= (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT);
    end

    // Read data mux; unmapped addresses read zero
    always_comb
    begin
        case (WB_ADR_IN)
            ADDR_STATUS: next_read = status;
            ADDR_CONTROL: next_read = control;
            ADDR_DATA: next_read = data_buffer;
            ADDR_BAUD: next_read = address_baud_register;
            default: next_read = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            WB_DAT_OUT <= 32'h00000000;
        else if (rd)
            WB_DAT_OUT <= {24'h000000, next_read};
    end

    // Control register: sticky flags clear only by writing zero
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            control <= CONTROL_RESET;
        else
        begin
            if (wr && lane0 && WB_ADR_IN == ADDR_CONTROL)
            begin
                control[5:0] <= wbyte[5:0];
                control[COLLISION_BIT] <= control[COLLISION_BIT] &
                    wbyte[COLLISION_BIT];
                control[OV_BIT] <= control[OV_BIT] & wbyte[OV_BIT];
            end
            // Set wins over a simultaneous clear
            if (collision_event)
                control[COLLISION_BIT] <= 1'b1;
            if (overflow_event)
                control[OV_BIT] <= 1'b1;
        end
    end

    // Status byte assembled from its individually owned fields
    assign status[SAMPLE_SEL_BIT] = spi_options[1];
    assign status[CKE_BIT] = spi_options[0];
    assign status[DA_BIT] = data_flag;
    assign status[STOP_BIT] = stop_flag;
    assign status[START_BIT] = start_flag;
    assign status[DIR_BIT] = direction_flag;
    assign status[UPDATE_ADDR_BIT] = update_address_flag;
    assign status[FULL_BIT] = buffer_full_flag;

    // Status: software owns the two SPI option bits only
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            spi_options <= STATUS_RESET[SAMPLE_SEL_BIT:CKE_BIT];
        else if (wr && lane0 && WB_ADR_IN == ADDR_STATUS)
            spi_options <= wbyte[SAMPLE_SEL_BIT:CKE_BIT];
    end

    // Start/stop flags: last condition seen, cleared on disable
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            stop_flag <= STATUS_RESET[STOP_BIT];
            start_flag <= STATUS_RESET[START_BIT];
        end
        else if (!control[EN_BIT] || !i2c)
        begin
            stop_flag <= 1'b0;
            start_flag <= 1'b0;
        end
        else if (EVENT_IN.stop_seen)
        begin
            stop_flag <= 1'b1;
            start_flag <= 1'b0;
        end
        else if (EVENT_IN.start_seen)
        begin
            start_flag <= 1'b1;
            stop_flag <= 1'b0;
        end
    end

    // Data/address, direction and update-address flags
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            data_flag <= STATUS_RESET[DA_BIT];
            direction_flag <= STATUS_RESET[DIR_BIT];
            update_address_flag <= STATUS_RESET[UPDATE_ADDR_BIT];
        end
        else
        begin
            if (i2c && EVENT_IN.byte_done)
                data_flag <= EVENT_IN.byte_is_data;
            if (mode.i2c_master)
                direction_flag <= EVENT_IN.tx_busy;
            else if (mode.i2c_slave && EVENT_IN.addr_match)
                direction_flag <= EVENT_IN.addr_rw;
            else if (EVENT_IN.start_seen || EVENT_IN.stop_seen ||
                EVENT_IN.nack_seen || !mode.i2c_slave)
                direction_flag <= 1'b0;
            if (mode.i2c_slave && mode.ten_bit && EVENT_IN.need_addr)
                update_address_flag <= 1'b1;
            else if (wr && lane0 && WB_ADR_IN == ADDR_BAUD)
                update_address_flag <= 1'b0;
        end
    end

    // Buffer full: receive fill, transmit busy, cleared by reads
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            buffer_full_flag <= STATUS_RESET[FULL_BIT];
        else if (i2c && EVENT_IN.tx_busy)
            buffer_full_flag <= 1'b1;
        else if (i2c && EVENT_IN.tx_done)
            buffer_full_flag <= 1'b0;
        else if (rx_take)
            buffer_full_flag <= 1'b1;
        else if (data_read)
            buffer_full_flag <= 1'b0;
    end

    // Data buffer: new byte lost on overflow
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            data_buffer <= DATA_RESET;
        else if (rx_take && !buffer_full_flag)
            data_buffer <= EVENT_IN.rx_byte;
        else if (data_write && !collision_event)
            data_buffer <= wbyte;
    end

    // Address and baud register
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            address_baud_register <= BAUD_RESET;
        else if (wr && lane0 && WB_ADR_IN == ADDR_BAUD)
            address_baud_register <= wbyte;
    end

    // Transmit launch pulse to the serial engine
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            TX_LOAD_OUT <= 1'b0;
            TX_BYTE_OUT <= 8'h00;
        end
        else
        begin
            TX_LOAD_OUT <= data_write && !collision_event &&
                control[EN_BIT];
            if (data_write)
                TX_BYTE_OUT <= wbyte;
        end
    end

    // Registered configuration outputs
    always_ff @(posedge CLOCK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            PORT_ENABLE_OUT <= 1'b0;
            MODE_SELECT_OUT <= 4'h0;
            SAMPLE_AT_END_OUT <= 1'b0;
            SHIFT_ON_IDLE_EDGE_OUT <= 1'b0;
            CLOCK_IDLE_HIGH_OUT <= 1'b0;
            SCL_HOLD_LOW_OUT <= 1'b0;
            BAUD_OUT <= 8'h00;
            PORT_IDLE_OUT <= 1'b1;
        end
        else
        begin
            PORT_ENABLE_OUT <= control[EN_BIT] && !mode.reserved;
            MODE_SELECT_OUT <= control[3:0];
            SAMPLE_AT_END_OUT <= mode.spi_master &&
                status[SAMPLE_SEL_BIT];
            SHIFT_ON_IDLE_EDGE_OUT <= status[CKE_BIT];
            CLOCK_IDLE_HIGH_OUT <= control[POLARITY_BIT];
            SCL_HOLD_LOW_OUT <= mode.i2c_slave && control[EN_BIT] &&
                !control[POLARITY_BIT];
            BAUD_OUT <= address_baud_register;
            PORT_IDLE_OUT <= !(status[DIR_BIT] ||
                (|MASTER_REQ_IN));
        end
    end

    // Checks on the flag behaviour
    chk_stop_disable: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        !control[EN_BIT] |=> !status[STOP_BIT] && !status[START_BIT])
        else $error("start or stop flag kept while disabled");
    chk_start_set: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        control[EN_BIT] && i2c && EVENT_IN.start_seen &&
        !EVENT_IN.stop_seen |=> status[START_BIT])
        else $error("start flag not set");
    chk_collision_set: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        collision_event |=> control[COLLISION_BIT])
        else $error("collision flag not set");
    chk_ov_master: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        mode.spi_master && !control[OV_BIT] |=> !control[OV_BIT])
        else $error("overflow in SPI master");
    chk_ov_keeps_buf: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        overflow_event && !data_write |=> $stable(data_buffer))
        else $error("buffer overwritten on overflow");
    chk_bf_rx: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        rx_take && !(i2c && EVENT_IN.tx_done) |=> buffer_full_flag)
        else $error("buffer full not set on receive");
    chk_bf_tx: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        i2c && EVENT_IN.tx_done && !EVENT_IN.tx_busy && !rx_take
        |=> !buffer_full_flag)
        else $error("buffer full stuck after transmit");
    chk_scl_hold: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        mode.i2c_master |=> !SCL_HOLD_LOW_OUT)
        else $error("clock held in master mode");
    chk_dir_master: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        mode.i2c_master |=> direction_flag == $past(EVENT_IN.tx_busy))
        else $error("master direction flag not tracking transmit");
    chk_ack_single: assert property (@(posedge CLOCK_IN)
        disable iff (!NRST_IN)
        WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("acknowledge held longer than one cycle");
endmodule // ssp_status_control
`default_nettype wire

// ### tb/serial_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the shift engine that reports bus events to the registers
module serial_engine_model
(
    input wire logic clk_in,
    output var ssp_regs_pkg::ssp_event_t event_out
);
    import ssp_regs_pkg::*;
    logic busy = 1'b0;
    logic [7:0] last = 8'h00;
    initial event_out = '0;
    // Quiet view between pulses; byte lines show no stale copy
    task automatic quiet();
        ssp_event_t q;
        q = '0;
        q.tx_busy = busy;
        q.rx_byte = ~last;
        event_out <= q;
    endtask
    // One-cycle event such as byte done, start, stop or address match
    task automatic pulse(input ssp_event_t e);
        @(posedge clk_in);
        e.tx_busy = busy;
        event_out <= e;
        last = e.rx_byte;
        @(posedge clk_in);
        quiet();
    endtask
    // Level that shows a byte still shifting out
    task automatic set_busy(input logic b);
        @(posedge clk_in);
        busy = b;
        quiet();
    endtask
endmodule // serial_engine_model
`default_nettype wire

// ### tb/ssp_status_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_status_control_tb_top;
    import ssp_regs_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, can_start = 1'b0, en, c_smp, c_cke, c_ckp, c_hold;
    logic t_load, idle;
    logic [4:0] req = 5'h00;
    logic [3:0] mode;
    logic [7:0] t_byte, baud, q;
    ssp_event_t ev;
    int errors = 0, samples_checked = 0, loads = 0;
    ssp_status_control u_ssp_status_control (.CLOCK_IN(clk), .NRST_IN(nrst),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .EVENT_IN(ev), .BUS_CAN_START_IN(can_start),
        .MASTER_REQ_IN(req), .PORT_ENABLE_OUT(en), .MODE_SELECT_OUT(mode),
        .SAMPLE_AT_END_OUT(c_smp), .SHIFT_ON_IDLE_EDGE_OUT(c_cke),
        .CLOCK_IDLE_HIGH_OUT(c_ckp), .SCL_HOLD_LOW_OUT(c_hold),
        .TX_BYTE_OUT(t_byte), .TX_LOAD_OUT(t_load), .BAUD_OUT(baud),
        .PORT_IDLE_OUT(idle));
    serial_engine_model u_serial_engine_model (.clk_in(clk), .event_out(ev));
    // 50 MHz clock
    initial forever #10 clk = ~clk;
    // Counts buffer load pulses
    always @(posedge clk) if (t_load === 1'b1) loads++;
    task automatic check(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50) check("ack", 0, 1);
        q = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [3:0] a, input logic [7:0] m,
            e);
        wb(1'b0, a, 8'h00);
        check(n, q & m, e);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Event kinds: 0 data, 1 address, 2 start, 3 stop, 4 match rd, 5 ua, 6 done
    task automatic fire(input int k, input logic [7:0] b);
        ssp_event_t e;
        e = '0;
        e.rx_byte = b;
        e.byte_done = (k < 2);
        e.byte_is_data = (k == 0);
        e.start_seen = (k == 2);
        e.stop_seen = (k == 3);
        e.addr_match = (k == 4);
        e.addr_rw = (k == 4);
        e.need_addr = (k == 5);
        e.tx_done = (k == 6);
        u_serial_engine_model.pulse(e);
        settle();
    endtask
    task automatic t_reset();
        check("idle", idle, 1);
        rd("status", ADDR_STATUS, 8'hFF, STATUS_RESET);
        rd("control", ADDR_CONTROL, 8'hFF, CONTROL_RESET);
        rd("unmapped", 4'h6, 8'hFF, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_status();
        wb(1, ADDR_CONTROL, 8'h20);
        wb(1, ADDR_STATUS, 8'hFF);
        rd("status", ADDR_STATUS, 8'hFF, 8'hC0);
        settle();
        check("sample end", c_smp, 1);
        check("cke", c_cke, 1);
        wb(1, ADDR_CONTROL, 8'h25);
        settle();
        check("sample slave", c_smp, 0);
        check("cke held", c_cke, 1);
        wb(1, ADDR_STATUS, 8'h00);
        settle();
        check("cke low", c_cke, 0);
        $display("test status done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 16; m++)
        begin
            wb(1, ADDR_CONTROL, {4'h2, m[3:0]});
            settle();
            check("mode", mode, m[3:0]);
            check("enable", en, !(m == 9 || m == 12 || m == 13));
            rd("control", ADDR_CONTROL, 8'hFF, {4'h2, m[3:0]});
        end
        wb(1, ADDR_CONTROL, 8'h36);
        settle();
        check("idle high", c_ckp, 1);
        check("hold", c_hold, 0);
        wb(1, ADDR_CONTROL, 8'h26);
        settle();
        check("idle low", c_ckp, 0);
        check("stretch", c_hold, 1);
        wb(1, ADDR_CONTROL, 8'h28);
        settle();
        check("master hold", c_hold, 0);
        $display("test modes done");
    endtask
    task automatic t_receive();
        wb(1, ADDR_CONTROL, 8'h25);
        fire(0, 8'hA5);
        rd("full", ADDR_STATUS, 8'h01, 8'h01);
        fire(0, 8'h3C);
        rd("overflow", ADDR_CONTROL, 8'h40, 8'h40);
        rd("kept byte", ADDR_DATA, 8'hFF, 8'hA5);
        rd("emptied", ADDR_STATUS, 8'h01, 8'h00);
        wb(1, ADDR_CONTROL, 8'hE5);
        rd("no set", ADDR_CONTROL, 8'hC0, 8'h40);
        wb(1, ADDR_CONTROL, 8'h25);
        rd("cleared", ADDR_CONTROL, 8'hC0, 8'h00);
        $display("test receive done");
    endtask
    task automatic t_i2c();
        wb(1, ADDR_CONTROL, 8'h26);
        fire(2, 8'h00);
        rd("start", ADDR_STATUS, 8'h18, 8'h08);
        fire(4, 8'h00);
        rd("read dir", ADDR_STATUS, 8'h04, 8'h04);
        fire(1, 8'h55);
        rd("address", ADDR_STATUS, 8'h20, 8'h00);
        rd("drain", ADDR_DATA, 8'hFF, 8'h55);
        fire(0, 8'h11);
        rd("data", ADDR_STATUS, 8'h21, 8'h21);
        fire(0, 8'h22);
        rd("overflow", ADDR_CONTROL, 8'h40, 8'h40);
        rd("kept byte", ADDR_DATA, 8'hFF, 8'h11);
        fire(3, 8'h00);
        rd("stop", ADDR_STATUS, 8'h18, 8'h10);
        wb(1, ADDR_CONTROL, 8'h06);
        rd("off", ADDR_STATUS, 8'h18, 8'h00);
        $display("test i2c done");
    endtask
    task automatic t_master();
        int n;
        wb(1, ADDR_CONTROL, 8'h28);
        wb(1, ADDR_DATA, 8'h77);
        rd("collide", ADDR_CONTROL, 8'h80, 8'h80);
        wb(1, ADDR_CONTROL, 8'h28);
        rd("collision clr", ADDR_CONTROL, 8'h80, 8'h00);
        can_start <= 1'b1;
        n = loads;
        wb(1, ADDR_DATA, 8'h5A);
        settle();
        check("tx byte", t_byte, 8'h5A);
        check("loads", loads - n, 1);
        rd("no collision", ADDR_CONTROL, 8'h80, 8'h00);
        u_serial_engine_model.set_busy(1'b1);
        settle();
        check("busy", idle, 0);
        rd("tx full", ADDR_STATUS, 8'h05, 8'h05);
        u_serial_engine_model.set_busy(1'b0);
        fire(6, 8'h00);
        rd("tx done", ADDR_STATUS, 8'h05, 8'h00);
        check("idle", idle, 1);
        for (int r = 0; r < 5; r++)
        begin
            @(posedge clk);
            req <= 5'h01 << r;
            settle();
            check("req", idle, 0);
        end
        @(posedge clk);
        req <= 5'h00;
        wb(1, ADDR_CONTROL, 8'h26);
        u_serial_engine_model.set_busy(1'b1);
        wb(1, ADDR_DATA, 8'h33);
        rd("slave collision", ADDR_CONTROL, 8'h80, 8'h80);
        u_serial_engine_model.set_busy(1'b0);
        $display("test master done");
    endtask
    task automatic t_update();
        wb(1, ADDR_CONTROL, 8'h27);
        fire(5, 8'h00);
        rd("update addr", ADDR_STATUS, 8'h02, 8'h02);
        wb(1, ADDR_BAUD, 8'h27);
        rd("update clr", ADDR_STATUS, 8'h02, 8'h00);
        rd("baud", ADDR_BAUD, 8'hFF, 8'h27);
        check("baud out", baud, 8'h27);
        $display("test update done");
    endtask
    // Hang guard, well above the length of all tests
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        settle();
        t_reset();
        t_status();
        t_modes();
        t_receive();
        t_i2c();
        t_master();
        t_update();
        end_of_test();
    end
endmodule // ssp_status_control_tb_top
`default_nettype wire
